// >>> fkp_defs.svh
// Offsets, field positions, reset values and key codes of the flash
// keyhole and protection register front end.
// Assumes 32-bit APB byte addresses.
`ifndef FKP_DEFS_SVH
`define FKP_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define FKP_ADDR_KEYHOLE     32'h4001_800C
`define FKP_ADDR_DATA_LOW    32'h4001_8010
`define FKP_ADDR_DATA_HIGH   32'h4001_8014
`define FKP_ADDR_PAGE_START  32'h4001_8018
`define FKP_ADDR_PAGE_END    32'h4001_801C
`define FKP_ADDR_UNLOCK_KEY  32'h4001_8020
`define FKP_ADDR_PROG_PROT   32'h4001_8028
`define FKP_ADDR_DATA_PROT   32'h4001_802C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FKP_KEYHOLE_MSB      22
`define FKP_KEYHOLE_LSB      3
`define FKP_PAGE_MSB         22
`define FKP_PAGE_LSB         6
`define FKP_KEY_MSB          15
`define FKP_DPROT_MSB        7

// ----------------------------------------------------------------------
// Reset values and key codes
// ----------------------------------------------------------------------
`define FKP_RST_KEYHOLE      20'h0_0000
`define FKP_RST_DATA_HIGH    32'h0000_0000
`define FKP_RST_PAGE         17'h0_0000
`define FKP_RST_PROG_PROT    32'hFFFF_FFFF
`define FKP_RST_DATA_PROT    8'hFF
`define FKP_KEY_FIRST        16'hF456
`define FKP_KEY_SECOND       16'hF123

`endif

// >>> fkp_pkg.sv
// Types of the flash keyhole and protection register front end.
// Assumes fkp_defs.svh is on the include path.
`include "fkp_defs.svh"

package fkp_pkg;

  // --------------------------------------------------------------------
  // Unlock sequence
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_ARMED,
    KEY_OPEN
  } fkp_key_state_t;

  typedef struct packed {
    fkp_key_state_t state;
    logic           open;
  } fkp_key_reg_t;

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [`FKP_KEYHOLE_MSB:`FKP_KEYHOLE_LSB] keyhole;
    logic [31:0]                              data_low;
    logic [31:0]                              data_high;
    logic [`FKP_PAGE_MSB:`FKP_PAGE_LSB]       page_start;
    logic [`FKP_PAGE_MSB:`FKP_PAGE_LSB]       page_end;
    logic [31:0]                              prog_prot;
    logic [`FKP_DPROT_MSB:0]                  data_prot;
    logic [31:0]                              rdata;
    logic                                     slverr;
  } fkp_regs_t;

endpackage : fkp_pkg

// >>> fkp_unlock.sv
// Two-word unlock key sequencer.
// Assumes key_wr is a one-cycle pulse from the register file.
`timescale 1ns/100ps
`include "fkp_defs.svh"

module fkp_unlock (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 key_wr,
  input  wire logic [`FKP_KEY_MSB:0] key_val,
  input  wire logic                 consume,
  output logic                      unlocked
);

  fkp_pkg::fkp_key_reg_t q;
  fkp_pkg::fkp_key_reg_t d;

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  always_comb begin
    d = q;
    if (key_wr) begin
      case (q.state)
        fkp_pkg::KEY_IDLE,
        fkp_pkg::KEY_OPEN: begin
          if (key_val == `FKP_KEY_FIRST) begin
            d.state = fkp_pkg::KEY_ARMED;
          end else begin
            d.state = fkp_pkg::KEY_IDLE;
          end
        end
        fkp_pkg::KEY_ARMED: begin
          if (key_val == `FKP_KEY_SECOND) begin
            d.state = fkp_pkg::KEY_OPEN;
          end else if (key_val == `FKP_KEY_FIRST) begin
            d.state = fkp_pkg::KEY_ARMED;
          end else begin
            d.state = fkp_pkg::KEY_IDLE;
          end
        end
        default: d.state = fkp_pkg::KEY_IDLE;
      endcase
    end else if (consume) begin
      // Any key write in the same cycle takes priority over consume
      d.state = fkp_pkg::KEY_IDLE;
    end
    d.open = (d.state == fkp_pkg::KEY_OPEN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{state: fkp_pkg::KEY_IDLE, open: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign unlocked = q.open;

endmodule : fkp_unlock

// >>> fkp_regs.sv
// Flash keyhole, page address, unlock key and write protection registers.
// Assumes an APB master on pclk; the command engine sits outside.
//
// Operation
// - The keyhole holds the flash location address in bits 22:3; the rest is reserved.
// - The lower write data register gives bits 31:0 of the 64-bit flash word.
// - The upper write data register gives bits 63:32 of the 64-bit flash word.
// - Boot firmware overwrites the lower data register with traceability data.
// - Boot firmware may leave a checksum in the upper data register.
// - The start page register holds bits 22:6, the first page for erase and sign.
// - The end page register holds bits 22:6, the last page for sign only.
// - The six low bits of both page registers are ignored on write and read as zero.
// - Writing the first key then the second key to the key register unlocks.
// - The program flash protect mask is 32 bits and read only once protection is set.
// - The data flash protect mask is 8 bits and read only once protection is set.
// - A mask bit at zero protects its flash section, a one leaves it open.
// - A write command takes its address from the keyhole and data from the data pair.
// - A page erase is accepted only after the unlock sequence was written.
`timescale 1ns/100ps
`include "fkp_defs.svh"

module fkp_regs #(
  parameter int unsigned ADDR_W         = 32,
  // Arbitrary neutral value, overwritten by boot firmware
  parameter logic [31:0] DATA_LOW_RESET = 32'h0000_0000
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              protect_programmed,
  input  wire logic              unlock_consume,
  output logic                   unlocked,
  output logic      [31:0]       flash_write_addr,
  output logic      [63:0]       flash_write_data,
  output logic      [31:0]       page_start_addr,
  output logic      [31:0]       page_end_addr,
  output logic      [31:0]       program_protect_mask,
  output logic      [7:0]        data_protect_mask
);

  // --------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------
  generate
    if (ADDR_W != 32) begin : g_bad_addr_w
      $error("fkp_regs: ADDR_W must be 32");
    end
  endgenerate

  fkp_pkg::fkp_regs_t q;
  fkp_pkg::fkp_regs_t d;

  logic        setup_ph;
  logic        access_ph;
  logic        wr_take;
  logic        mapped;
  logic [31:0] rd_mux;
  logic        key_wr;

  // --------------------------------------------------------------------
  // APB phases
  // --------------------------------------------------------------------
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  // Zero wait states: pready is high in every access phase
  assign pready    = 1'b1;
  assign wr_take   = access_ph & pwrite;

  // --------------------------------------------------------------------
  // Address decode and read mux
  // --------------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `FKP_ADDR_KEYHOLE: begin
        rd_mux[`FKP_KEYHOLE_MSB:`FKP_KEYHOLE_LSB] = q.keyhole;
      end
      `FKP_ADDR_DATA_LOW: begin
        rd_mux = q.data_low;
      end
      `FKP_ADDR_DATA_HIGH: begin
        rd_mux = q.data_high;
      end
      `FKP_ADDR_PAGE_START: begin
        rd_mux[`FKP_PAGE_MSB:`FKP_PAGE_LSB] = q.page_start;
      end
      `FKP_ADDR_PAGE_END: begin
        rd_mux[`FKP_PAGE_MSB:`FKP_PAGE_LSB] = q.page_end;
      end
      `FKP_ADDR_UNLOCK_KEY: begin
        rd_mux = 32'h0000_0000;
      end
      `FKP_ADDR_PROG_PROT: begin
        rd_mux = q.prog_prot;
      end
      `FKP_ADDR_DATA_PROT: begin
        rd_mux[`FKP_DPROT_MSB:0] = q.data_prot;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    d      = q;
    key_wr = 1'b0;

    // Read data and error are captured in the setup cycle so that
    // both stand from flops through the access phase
    if (setup_ph) begin
      d.rdata  = pwrite ? 32'h0000_0000 : rd_mux;
      d.slverr = ~mapped;
    end

    if (wr_take && mapped) begin
      case (paddr)
        `FKP_ADDR_KEYHOLE: begin
          d.keyhole = pwdata[`FKP_KEYHOLE_MSB:`FKP_KEYHOLE_LSB];
        end
        `FKP_ADDR_DATA_LOW: begin
          d.data_low = pwdata;
        end
        `FKP_ADDR_DATA_HIGH: begin
          d.data_high = pwdata;
        end
        `FKP_ADDR_PAGE_START: begin
          d.page_start = pwdata[`FKP_PAGE_MSB:`FKP_PAGE_LSB];
        end
        `FKP_ADDR_PAGE_END: begin
          d.page_end = pwdata[`FKP_PAGE_MSB:`FKP_PAGE_LSB];
        end
        `FKP_ADDR_UNLOCK_KEY: begin
          key_wr = 1'b1;
        end
        `FKP_ADDR_PROG_PROT: begin
          if (!protect_programmed) begin
            d.prog_prot = pwdata;
          end
        end
        `FKP_ADDR_DATA_PROT: begin
          if (!protect_programmed) begin
            d.data_prot = pwdata[`FKP_DPROT_MSB:0];
          end
        end
        default: begin
          key_wr = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.keyhole    <= `FKP_RST_KEYHOLE;
      q.data_low   <= DATA_LOW_RESET;
      q.data_high  <= `FKP_RST_DATA_HIGH;
      q.page_start <= `FKP_RST_PAGE;
      q.page_end   <= `FKP_RST_PAGE;
      q.prog_prot  <= `FKP_RST_PROG_PROT;
      q.data_prot  <= `FKP_RST_DATA_PROT;
      q.rdata      <= 32'h0000_0000;
      q.slverr     <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------
  // Unlock key sequencer
  // --------------------------------------------------------------------
  fkp_unlock u_unlock (
    .pclk     (pclk),
    .presetn  (presetn),
    .key_wr   (key_wr),
    .key_val  (pwdata[`FKP_KEY_MSB:0]),
    .consume  (unlock_consume),
    .unlocked (unlocked)
  );

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata  = q.rdata;
  assign pslverr = q.slverr;

  // Write command target and 64-bit word
  always_comb begin
    flash_write_addr = 32'h0000_0000;
    flash_write_addr[`FKP_KEYHOLE_MSB:`FKP_KEYHOLE_LSB] = q.keyhole;
  end
  assign flash_write_data = {q.data_high, q.data_low};

  // Page addresses with low byte bits and upper bits at zero
  always_comb begin
    page_start_addr = 32'h0000_0000;
    page_end_addr   = 32'h0000_0000;
    page_start_addr[`FKP_PAGE_MSB:`FKP_PAGE_LSB] = q.page_start;
    page_end_addr[`FKP_PAGE_MSB:`FKP_PAGE_LSB]   = q.page_end;
  end

  // Zero bit protects, one bit leaves open; passed as stored
  assign program_protect_mask = q.prog_prot;
  assign data_protect_mask    = q.data_prot;

endmodule : fkp_regs

// >>> fkp_regs_checker.sv
// Port assertions for the flash keyhole and protection registers.
// Assumes it is bound into fkp_regs; one clock pclk, reset presetn.
`timescale 1ns/100ps
`include "fkp_defs.svh"

module fkp_regs_checker #(
  parameter int unsigned ADDR_W = 32
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              protect_programmed,
  input wire logic              unlock_consume,
  input wire logic              unlocked,
  input wire logic [31:0]       flash_write_addr,
  input wire logic [63:0]       flash_write_data,
  input wire logic [31:0]       page_start_addr,
  input wire logic [31:0]       page_end_addr,
  input wire logic [31:0]       program_protect_mask,
  input wire logic [7:0]        data_protect_mask
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  logic wr_en;
  logic key_wr;
  logic key_second;
  assign wr_en      = psel & penable & pwrite;
  assign key_wr     = wr_en & (paddr == `FKP_ADDR_UNLOCK_KEY);
  assign key_second = key_wr & (pwdata[15:0] == `FKP_KEY_SECOND);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_keyhole_reserved: assert property (
    flash_write_addr[31:23] == 9'h000 && flash_write_addr[2:0] == 3'h0)
    else $error("keyhole reserved bits set");
  a_page_low_zero: assert property (
    page_start_addr[5:0] == 6'h00 && page_end_addr[5:0] == 6'h00)
    else $error("page low bits set");
  a_data_low_write: assert property (
    wr_en && paddr == `FKP_ADDR_DATA_LOW |=> flash_write_data[31:0] == $past(pwdata))
    else $error("low data word not stored");
  a_unlock_cause: assert property (
    $rose(unlocked) |-> $past(key_second))
    else $error("unlock without second key");
  a_bad_key_drop: assert property (
    key_wr && pwdata[15:0] != `FKP_KEY_SECOND |=> !unlocked)
    else $error("unlock kept after other key");
  a_consume_drop: assert property (
    unlock_consume && !key_wr |=> !unlocked)
    else $error("unlock kept after consume");
  a_prog_locked: assert property (
    protect_programmed |=> $stable(program_protect_mask))
    else $error("program mask changed while locked");
  a_data_locked: assert property (
    protect_programmed |=> $stable(data_protect_mask))
    else $error("data mask changed while locked");
  a_key_read_zero: assert property (
    psel && !penable && !pwrite && paddr == `FKP_ADDR_UNLOCK_KEY |=> prdata == 32'h0)
    else $error("key read not zero");
  a_keyhole_store: assert property (
    wr_en && paddr == `FKP_ADDR_KEYHOLE |=>
      flash_write_addr == ($past(pwdata) & 32'h007F_FFF8))
    else $error("keyhole word not stored");
  a_data_high_write: assert property (
    wr_en && paddr == `FKP_ADDR_DATA_HIGH |=> flash_write_data[63:32] == $past(pwdata))
    else $error("high data word not stored");
  a_page_start_store: assert property (
    wr_en && paddr == `FKP_ADDR_PAGE_START |=>
      page_start_addr == ($past(pwdata) & 32'h007F_FFC0))
    else $error("start page not stored");
  a_page_end_store: assert property (
    wr_en && paddr == `FKP_ADDR_PAGE_END |=>
      page_end_addr == ($past(pwdata) & 32'h007F_FFC0))
    else $error("end page not stored");

  c_unlock: cover property ($rose(unlocked));
  c_locked_write: cover property (protect_programmed && wr_en);
  c_unmapped: cover property (pslverr);
endmodule : fkp_regs_checker

bind fkp_regs fkp_regs_checker #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .protect_programmed(protect_programmed),
  .unlock_consume(unlock_consume), .unlocked(unlocked),
  .flash_write_addr(flash_write_addr), .flash_write_data(flash_write_data),
  .page_start_addr(page_start_addr), .page_end_addr(page_end_addr),
  .program_protect_mask(program_protect_mask), .data_protect_mask(data_protect_mask));

// >>> fkp_regs_tb.sv
// Self-checking bench: APB read and write sequences with expected values.
// Assumes fkp_defs.svh on the include path and the checker bound in.
`timescale 1ns/100ps
`include "fkp_defs.svh"

module fkp_regs_tb;
  localparam logic [31:0] DLR    = 32'h5A5A_0001;
  localparam logic [31:0] RA [8] = '{`FKP_ADDR_KEYHOLE, `FKP_ADDR_DATA_LOW,
    `FKP_ADDR_DATA_HIGH, `FKP_ADDR_PAGE_START, `FKP_ADDR_PAGE_END,
    `FKP_ADDR_UNLOCK_KEY, `FKP_ADDR_PROG_PROT, `FKP_ADDR_DATA_PROT};
  localparam logic [31:0] RV [8] = '{32'h0, DLR, 32'h0, 32'h0, 32'h0, 32'h0,
    32'hFFFF_FFFF, 32'hFF};
  // Page writes keep bits 31:23 at zero
  localparam logic [31:0] WV [8] = '{32'hFFFF_FFFF, 32'h1234_5678, 32'h9ABC_DEF0,
    32'h007F_FFFF, 32'h0012_3456, 32'h0000_F456, 32'hA5A5_5A5A, 32'h0000_013C};
  localparam logic [31:0] XV [8] = '{32'h007F_FFF8, 32'h1234_5678, 32'h9ABC_DEF0,
    32'h007F_FFC0, 32'h0012_3440, 32'h0, 32'hA5A5_5A5A, 32'h3C};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        protect_programmed, unlock_consume, unlocked;
  logic [31:0] paddr, pwdata, prdata, rd, flash_write_addr;
  logic [31:0] page_start_addr, page_end_addr, program_protect_mask;
  logic [63:0] flash_write_data;
  logic [7:0]  data_protect_mask;
  int          errors, n_tests;

  fkp_regs #(.ADDR_W(32), .DATA_LOW_RESET(DLR)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .protect_programmed(protect_programmed),
    .unlock_consume(unlock_consume), .unlocked(unlocked),
    .flash_write_addr(flash_write_addr), .flash_write_data(flash_write_data),
    .page_start_addr(page_start_addr), .page_end_addr(page_end_addr),
    .program_protect_mask(program_protect_mask), .data_protect_mask(data_protect_mask));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ul(input logic exp);
    @(negedge pclk);
    check("unlocked", unlocked, exp);
  endtask : ul

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // --------------------------------------------------------------------
  // Clock, watchdog and sequence
  // --------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    end_of_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, protect_programmed, unlock_consume} = 6'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    errors = 0;
    n_tests = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, RA[i], 32'h0);
      check("reset value", rd, RV[i]);
      check("slverr", er, 1'b0);
    end
    for (int i = 0; i < 8; i++) apb(1'b1, RA[i], WV[i]);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, RA[i], 32'h0);
      check("readback", rd, XV[i]);
    end
    check("write addr", flash_write_addr, XV[0]);
    check("write data", flash_write_data, {XV[2], XV[1]});
    check("start page", page_start_addr, XV[3]);
    check("end page", page_end_addr, XV[4]);
    check("prog mask", program_protect_mask, XV[6]);
    protect_programmed <= 1'b1;
    apb(1'b1, `FKP_ADDR_PROG_PROT, 32'h0);
    apb(1'b1, `FKP_ADDR_DATA_PROT, 32'h0);
    apb(1'b0, `FKP_ADDR_PROG_PROT, 32'h0);
    check("prog locked", rd, XV[6]);
    apb(1'b0, `FKP_ADDR_DATA_PROT, 32'h0);
    check("data locked", rd, XV[7]);
    protect_programmed <= 1'b0;
    apb(1'b1, `FKP_ADDR_DATA_PROT, 32'h0);
    ul(1'b0);
    check("data mask", data_protect_mask, 8'h00);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'hFFFF_F456);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'h0000_F123);
    ul(1'b1);
    apb(1'b0, `FKP_ADDR_UNLOCK_KEY, 32'h0);
    check("key read", rd, 32'h0);
    unlock_consume <= 1'b1;
    @(posedge pclk);
    unlock_consume <= 1'b0;
    ul(1'b0);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'h0000_F456);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'h0000_1111);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'h0000_F123);
    ul(1'b0);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'h0000_F456);
    apb(1'b1, `FKP_ADDR_KEYHOLE, 32'h0000_0008);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'h0000_F123);
    ul(1'b1);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'h0000_ABCD);
    ul(1'b0);
    apb(1'b0, 32'h4001_8024, 32'h0);
    check("unmapped err", er, 1'b1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'h0000_F456);
    apb(1'b1, `FKP_ADDR_UNLOCK_KEY, 32'h0000_F123);
    ul(1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ul(1'b0);
    apb(1'b0, `FKP_ADDR_PROG_PROT, 32'h0);
    check("prog reset", rd, 32'hFFFF_FFFF);
    check("keyhole reset", flash_write_addr, 64'h0);
    end_of_test();
  end
endmodule : fkp_regs_tb
